// >>> core/tps_regs.sv
/*
  Test-page register group: output driver enables, port levels with pin
  readback, probe bus view, self-test control and revision, reached over
  an Avalon-MM slave with waitrequest.
  Assumes a synchronous bus master on mclk, synchronous pin inputs, and
  an external probe bus already selected by the probe select register.
*/
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
// Contract
// RL1 - UART lines off when enable bit clear
// RL2 - Driver enable register resets to 80h
// RL3 - Enable bits 6..1 turn pin drivers on
// RL4 - Enable bit index equals pin index
// RL5 - SPI host uses only pins D1..D4
// RL6 - UART with lines on uses D1..D4
// RL7 - Port I/O bit makes general port; here only while serialHostActive is also high
// RL8 - Enabled pins drive stored level bits
// RL9 - I/O mode read returns pin states
// RL10 - Otherwise read returns stored contents
// RL11 - Port level register resets to 00h
// RL12 - Probe view returns selected bus bits
// RL13 - Nonlinear bit sets receiver nonlinear
// RL14 - Self-test register resets to 40h
// RL15 - Field code 1001b arms self-test
// RL16 - Checksum command starts armed self-test
// RL17 - Software clears field before normal use
// RL18 - Revision register returns version code
// RL19 - Selected probe bit drives auxiliary output
// RL20 - Read-only and reserved writes ignored, zero
module tps_regs #(
  parameter int NUM_PINS = 6,
  parameter int PROBE_WIDTH = 8,
  parameter int BIT_SEL_WIDTH = 3,
  parameter logic [7:0] REVISION = tps_pkg::REVISION_DEFAULT
) (
  input wire logic mclk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic [1:0] response,
  output logic waitrequest,
  // Host interface and command context
  input wire logic serialHostActive,
  input wire logic checksumCalculateCommand,
  // Test port pins D1..D6
  input wire logic [NUM_PINS:1] pinIn,
  output logic [NUM_PINS:1] pinOut,
  output logic [NUM_PINS:1] pinOe,
  // Probe bus and auxiliary output
  input wire logic [PROBE_WIDTH-1:0] probeBus,
  input wire logic auxSelect,
  input wire logic [BIT_SEL_WIDTH-1:0] probeBitSelect,
  output logic auxiliaryOutputPin,
  // Control outputs
  output logic uartMxLineEnable,
  output logic uartRequestLineEnable,
  output logic nonlinearReceive,
  output logic selfTestEnabled,
  output logic selfTestStart
);

  tps_pkg::tps_bus_state_t busState;
  tps_pkg::tps_bus_state_t next_busState;

  logic [7:0] driverEnableReg;
  logic [7:0] portLevelReg;
  logic [7:0] selfTestReg;

  // Address decode
  wire logic alignedAddr = (address[1:0] == 2'b00);
  wire logic [5:0] regIndex = address[7:2];
  wire logic hitDrvEn = alignedAddr && (regIndex == tps_pkg::IDX_DRV_EN);
  wire logic hitPortLevel = alignedAddr && (regIndex == tps_pkg::IDX_PORT_LEVEL);
  wire logic hitProbeView = alignedAddr && (regIndex == tps_pkg::IDX_PROBE_VIEW);
  wire logic hitSelfTest = alignedAddr && (regIndex == tps_pkg::IDX_SELF_TEST);
  wire logic hitRevision = alignedAddr && (regIndex == tps_pkg::IDX_REVISION);
  wire logic hitAny = hitDrvEn | hitPortLevel | hitProbeView | hitSelfTest | hitRevision;

  // Request taken on the edge at which waitrequest is seen low
  wire logic request = read | write;
  wire logic commit = (busState == tps_pkg::ST_ANSWER);
  wire logic lowLane = byteenable[0];
  wire logic writeCommit = commit && write && lowLane;
  wire logic [7:0] writeByte = writedata[7:0];

  // RL20 masked writable bits
  wire logic [7:0] maskedDrvEn = writeByte & tps_pkg::DRV_EN_MASK;
  wire logic [7:0] maskedPortLevel = writeByte & tps_pkg::PORT_LEVEL_MASK;
  wire logic [7:0] maskedSelfTest = writeByte & tps_pkg::SELF_TEST_MASK;

  // Field views
  wire logic uartLineEnable = driverEnableReg[tps_pkg::UART_LINE_EN_BIT];
  wire logic [NUM_PINS:1] pinDriverEnable =
    driverEnableReg[tps_pkg::PIN_MSB:tps_pkg::PIN_LSB];
  wire logic portIoEnable = portLevelReg[tps_pkg::PORT_IO_EN_BIT];
  wire logic [NUM_PINS:1] portLevelField =
    portLevelReg[tps_pkg::PIN_MSB:tps_pkg::PIN_LSB];
  wire logic [3:0] selfTestField =
    selfTestReg[tps_pkg::SELF_TEST_MSB:tps_pkg::SELF_TEST_LSB];

  // RL7 general port mode
  wire logic ioMode = portIoEnable & serialHostActive;

  // RL15 arm code
  wire logic selfTestArmed = (selfTestField == tps_pkg::SELF_TEST_ARM);

  // Test signal per pin comes from the probe bus bit of the same index
  wire logic [NUM_PINS:1] pinTestSignal = probeBus[NUM_PINS:1];

  // RL9 RL10 port level readback source
  wire logic [7:0] portLevelRead = portIoEnable ?
    {portIoEnable, pinIn, 1'b0} : portLevelReg;

  // RL12 probe bus view
  wire logic [7:0] probeViewRead = probeBus[7:0];

  // RL18 revision code
  wire logic [7:0] revisionRead = REVISION;

  // Read multiplexer
  wire logic [7:0] readByte =
    hitDrvEn ? driverEnableReg :
    hitPortLevel ? portLevelRead :
    hitProbeView ? probeViewRead :
    hitSelfTest ? selfTestReg :
    hitRevision ? revisionRead :
    tps_pkg::BYTE_ZERO;

  wire logic [31:0] readWord = {24'h000000, readByte};
  wire logic [1:0] nextResponse = hitAny ? tps_pkg::RESP_OKAY : tps_pkg::RESP_DECODEERROR;

  // Bus slave state: one wait cycle, then the answer cycle
  always_comb begin
    next_busState = busState;
    case (busState)
      tps_pkg::ST_IDLE: begin
        if (request) begin
          next_busState = tps_pkg::ST_ANSWER;
        end
      end
      tps_pkg::ST_ANSWER: begin
        next_busState = tps_pkg::ST_IDLE;
      end
      default: begin
        next_busState = tps_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      busState <= tps_pkg::ST_IDLE;
    end else begin
      busState <= next_busState;
    end
  end

  // Waitrequest drops for exactly the answer cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= (next_busState != tps_pkg::ST_ANSWER);
    end
  end

  // Read data and response captured as the answer cycle opens
  always_ff @(posedge mclk) begin
    if (reset) begin
      readdata <= tps_pkg::WORD_ZERO;
      response <= tps_pkg::RESP_OKAY;
    end else if (busState == tps_pkg::ST_IDLE && request) begin
      readdata <= read ? readWord : tps_pkg::WORD_ZERO;
      response <= nextResponse;
    end
  end

  // RL2 reset 80h
  always_ff @(posedge mclk) begin
    if (reset) begin
      driverEnableReg <= tps_pkg::DRV_EN_RESET;
    end else if (writeCommit && hitDrvEn) begin
      driverEnableReg <= maskedDrvEn;
    end
  end

  // RL11 reset 00h
  always_ff @(posedge mclk) begin
    if (reset) begin
      portLevelReg <= tps_pkg::PORT_LEVEL_RESET;
    end else if (writeCommit && hitPortLevel) begin
      portLevelReg <= maskedPortLevel;
    end
  end

  // RL14 reset 40h
  always_ff @(posedge mclk) begin
    if (reset) begin
      selfTestReg <= tps_pkg::SELF_TEST_RESET;
    end else if (writeCommit && hitSelfTest) begin
      selfTestReg <= maskedSelfTest;
    end
  end

  // Control outputs, registered
  always_ff @(posedge mclk) begin
    if (reset) begin
      uartMxLineEnable <= tps_pkg::DRV_EN_RESET[tps_pkg::UART_LINE_EN_BIT];
      uartRequestLineEnable <= tps_pkg::DRV_EN_RESET[tps_pkg::UART_LINE_EN_BIT];
      nonlinearReceive <= tps_pkg::SELF_TEST_RESET[tps_pkg::NONLINEAR_BIT];
      selfTestEnabled <= 1'b0;
    end else begin
      // RL1 UART lines gated
      uartMxLineEnable <= uartLineEnable;
      uartRequestLineEnable <= uartLineEnable;
      // RL13 nonlinear receiver
      nonlinearReceive <= selfTestReg[tps_pkg::NONLINEAR_BIT];
      selfTestEnabled <= selfTestArmed;
    end
  end

  // Self-test start is high one cycle after each armed cycle of the checksum command
  always_ff @(posedge mclk) begin
    if (reset) begin
      selfTestStart <= 1'b0;
    end else begin
      // RL16 command starts self-test
      selfTestStart <= checksumCalculateCommand & selfTestArmed;
    end
  end

  tps_pin_port #(
    .NUM_PINS(NUM_PINS)
  ) u_pin_port (
    .mclk(mclk),
    .reset(reset),
    .ioMode(ioMode),
    .driverEnable(pinDriverEnable),
    .levelBits(portLevelField),
    .testSignal(pinTestSignal),
    .pinOut(pinOut),
    .pinOe(pinOe)
  );

  tps_aux_mux #(
    .BUS_WIDTH(PROBE_WIDTH),
    .SEL_WIDTH(BIT_SEL_WIDTH)
  ) u_aux_mux (
    .mclk(mclk),
    .reset(reset),
    .auxSelect(auxSelect),
    .bitSelect(probeBitSelect),
    .probeBus(probeBus),
    .auxOut(auxiliaryOutputPin)
  );

endmodule : tps_regs

// >>> core/tps_pkg.sv
/*
  Constants for the test-port and self-test register group: register
  indices, field positions, write masks, reset values and bus codes.
  Assumes nothing of its surroundings; tps_regs, the checker and the testbench refer here.
*/
package tps_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_DRV_EN = 6'h33;
  localparam logic [5:0] IDX_PORT_LEVEL = 6'h34;
  localparam logic [5:0] IDX_PROBE_VIEW = 6'h35;
  localparam logic [5:0] IDX_SELF_TEST = 6'h36;
  localparam logic [5:0] IDX_REVISION = 6'h37;

  // Field positions
  localparam int UART_LINE_EN_BIT = 7;
  localparam int PORT_IO_EN_BIT = 7;
  localparam int NONLINEAR_BIT = 6;
  localparam int PIN_LSB = 1;
  localparam int PIN_MSB = 6;
  localparam int SELF_TEST_LSB = 0;
  localparam int SELF_TEST_MSB = 3;

  // Writable bits of each register; the rest read as zero
  localparam logic [7:0] DRV_EN_MASK = 8'hFE;
  localparam logic [7:0] PORT_LEVEL_MASK = 8'hFE;
  localparam logic [7:0] SELF_TEST_MASK = 8'h4F;

  // Reset values
  localparam logic [7:0] DRV_EN_RESET = 8'h80;
  localparam logic [7:0] PORT_LEVEL_RESET = 8'h00;
  localparam logic [7:0] SELF_TEST_RESET = 8'h40;

  // Self-test field code that arms the self-test
  localparam logic [3:0] SELF_TEST_ARM = 4'h9;

  // Avalon-MM response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECODEERROR = 2'h3;

  // Revision code; value is arbitrary
  localparam logic [7:0] REVISION_DEFAULT = 8'h5A;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ANSWER = 2'b10
  } tps_bus_state_t;

endpackage : tps_pkg

// >>> core/tps_pin_port.sv
/*
  Per-pin driver stage of the test port: output enable and output level
  flip-flops for each data pin.
  Assumes enables and levels arrive as synchronous vectors, one bit per pin.
*/
`timescale 1ns/1ps
module tps_pin_port #(
  parameter int NUM_PINS = 6
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ioMode,
  input wire logic [NUM_PINS:1] driverEnable,
  input wire logic [NUM_PINS:1] levelBits,
  input wire logic [NUM_PINS:1] testSignal,
  output logic [NUM_PINS:1] pinOut,
  output logic [NUM_PINS:1] pinOe
);

  genvar i;
  generate
    for (i = 1; i <= NUM_PINS; i++) begin : g_pin
      // RL4 same index mapping
      wire logic nextOut = ioMode ? levelBits[i] : testSignal[i];
      always_ff @(posedge mclk) begin
        if (reset) begin
          pinOe[i] <= 1'b0;
          pinOut[i] <= 1'b0;
        end else begin
          // RL3 RL8 enabled pins drive
          pinOe[i] <= driverEnable[i];
          pinOut[i] <= driverEnable[i] & nextOut;
        end
      end
    end
  endgenerate

endmodule : tps_pin_port

// >>> core/tps_aux_mux.sv
/*
  Selects one bit of the probe bus and drives it onto the auxiliary
  output pin, registered.
  Assumes the probe bus and the bit select are synchronous to mclk.
*/
`timescale 1ns/1ps
module tps_aux_mux #(
  parameter int BUS_WIDTH = 8,
  parameter int SEL_WIDTH = 3
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic auxSelect,
  input wire logic [SEL_WIDTH-1:0] bitSelect,
  input wire logic [BUS_WIDTH-1:0] probeBus,
  output logic auxOut
);

  wire logic selectedBit = probeBus[bitSelect];

  always_ff @(posedge mclk) begin
    if (reset) begin
      auxOut <= 1'b0;
    end else begin
      // RL19 chosen bit out
      auxOut <= auxSelect & selectedBit;
    end
  end

endmodule : tps_aux_mux

// >>> testbench/tps_regs_chk.sv
/*
  Assertions on the ports of tps_regs.
  Assumes one clock and a synchronous reset.
*/
`timescale 1ns/1ps
module tps_regs_chk #(
  parameter int NUM_PINS = 6,
  parameter int PROBE_WIDTH = 8,
  parameter int BIT_SEL_WIDTH = 3,
  parameter logic [7:0] REVISION = tps_pkg::REVISION_DEFAULT
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic [1:0] response,
  input wire logic waitrequest,
  input wire logic serialHostActive,
  input wire logic checksumCalculateCommand,
  input wire logic [NUM_PINS:1] pinOut,
  input wire logic [NUM_PINS:1] pinOe,
  input wire logic [PROBE_WIDTH-1:0] probeBus,
  input wire logic auxSelect,
  input wire logic [BIT_SEL_WIDTH-1:0] probeBitSelect,
  input wire logic auxiliaryOutputPin,
  input wire logic uartMxLineEnable,
  input wire logic selfTestEnabled,
  input wire logic selfTestStart
);
  wire logic commit = write && !waitrequest && byteenable[0];
  wire logic seen = read && waitrequest;
  wire logic odd = address < 8'hCC || address > 8'hDC || address[1:0] != 2'h0;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_uart_follow: assert property (
    commit && address == 8'hCC |-> ##2 uartMxLineEnable == $past(writedata[7], 2))
    else $error("uart enable wrong");
  a_pin_enable: assert property (
    commit && address == 8'hCC |-> ##2 pinOe == $past(writedata[6:1], 2))
    else $error("pin enable wrong");
  a_io_level: assert property (
    commit && address == 8'hD0 && writedata[7] ##1 serialHostActive [*2]
    |=> pinOut == ($past(writedata[6:1], 3) & pinOe)) else $error("pin level wrong");
  a_revision_read: assert property (
    seen && address == 8'hDC |=> readdata == {24'h000000, REVISION})
    else $error("revision wrong");
  a_arm_code: assert property (
    commit && address == 8'hD8 && writedata[3:0] == 4'h9 |-> ##[1:2] selfTestEnabled)
    else $error("self-test not armed");
  a_start_taken: assert property (
    checksumCalculateCommand && selfTestEnabled && $past(selfTestEnabled) |=> selfTestStart)
    else $error("self-test not started");
  a_aux_drive: assert property (
    auxSelect && probeBus[probeBitSelect] |=> auxiliaryOutputPin) else $error("aux low");
  a_unmapped_read: assert property (
    seen && odd |=> readdata == 32'h00000000 && response == 2'h3)
    else $error("unmapped read wrong");
endmodule : tps_regs_chk

bind tps_regs tps_regs_chk #(.NUM_PINS(NUM_PINS), .PROBE_WIDTH(PROBE_WIDTH),
  .BIT_SEL_WIDTH(BIT_SEL_WIDTH), .REVISION(REVISION)) u_chk (.*);

// >>> testbench/testbench.sv
/*
  Random register traffic on tps_regs, compared with a register model.
  Assumes the design and the checker are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  logic mclk = 0, reset = 1, read = 0, write = 0, auxSelect = 0;
  logic serialHostActive = 0, checksumCalculateCommand = 0;
  logic [7:0] address = 8'h00, probeBus = 8'h00;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0, readdata, rdat, r;
  logic [1:0] response, rsp;
  logic [6:1] pinIn = 6'h00, pinOut, pinOe;
  logic [2:0] probeBitSelect = 3'h0;
  logic waitrequest, auxiliaryOutputPin, uartMxLineEnable, uartRequestLineEnable;
  logic nonlinearReceive, selfTestEnabled, selfTestStart;
  int mismatches = 0, n_compared = 0, seed = 58;
  int drv = 8'h80, lvl = 8'h00, st = 8'h40;
  int addrs[$] = '{8'hCC, 8'hD0, 8'hD4, 8'hD8, 8'hDC};
  tps_regs DUT (.*);
  initial forever #50 mclk = ~mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic be);
    address <= a;
    writedata <= {24'h000000, d};
    byteenable <= {3'h7, be};
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    rdat = readdata;
    rsp = response;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge mclk);
    if (wr && be) begin
      if (a == 8'hCC) drv = d & 8'hFE;
      if (a == 8'hD0) lvl = d & 8'hFE;
      if (a == 8'hD8) st = d & 8'h4F;
    end
  endtask : bus
  function automatic int expRead(input logic [7:0] a);
    case (a)
      8'hCC: return drv;
      8'hD0: return lvl[7] ? {1'b1, pinIn, 1'b0} : lvl;
      8'hD4: return probeBus;
      8'hD8: return st;
      8'hDC: return tps_pkg::REVISION_DEFAULT;
      default: return 0;
    endcase
  endfunction : expRead
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00, 1'b1);
    chk(rdat, expRead(a));
    chk(rsp, (a >= 8'hCC && a <= 8'hDC && a[1:0] == 2'h0) ? 2'h0 : 2'h3);
  endtask : rd
  task automatic pins;
    chk(pinOe, drv[6:1]);
    chk(pinOut, drv[6:1] & (lvl[7] && serialHostActive ? lvl[6:1] : probeBus[6:1]));
    chk(uartMxLineEnable, drv[7]);
    chk(uartRequestLineEnable, drv[7]);
    chk(nonlinearReceive, st[6]);
    chk(selfTestEnabled, st[3:0] == 4'h9);
    chk(auxiliaryOutputPin, auxSelect & probeBus[probeBitSelect]);
  endtask : pins
  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    #(3000 * 100);
    mismatches++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    foreach (addrs[k]) rd(addrs[k]);
    pins();
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      pinIn <= r[5:0];
      probeBus <= r[13:6];
      serialHostActive <= r[14];
      auxSelect <= r[15];
      probeBitSelect <= r[18:16];
      // no high pins enabled by a write made while a serial host is in use
      bus(1'b1, 8'hCC, r[31:24] & (r[14] ? 8'h9F : 8'hFF), r[19] | i[0]);
      r = $random(seed);
      bus(1'b1, 8'hD0, r[7:0], 1'b1);
      bus(1'b1, 8'hD8, i[0] ? {r[15:12], 4'h9} : r[15:8], 1'b1);
      bus(1'b1, r[23:16], r[31:24], 1'b1);
      foreach (addrs[k]) rd(addrs[k]);
      rd(r[23:16] + 8'h01);
      checksumCalculateCommand <= 1'b1;
      @(posedge mclk);
      checksumCalculateCommand <= 1'b0;
      @(negedge mclk);
      chk(selfTestStart, st[3:0] == 4'h9);
      @(posedge mclk);
      pins();
      $display("test %0d done", i);
    end
    bus(1'b1, 8'hD8, 8'h40, 1'b1);
    rd(8'hD8);
    pins();
    $display("test disarm done");
    summarize();
  end
endmodule : testbench
